// ### src/rsow_pkg.sv
// Package of constants for the reset sequencer and oscillation-stability wait.
// Assumes a single system clock domain; no registers reached by software.
package rsow_pkg;
    // -------------------------------------------------------------------------
    // Widths and counts
    // -------------------------------------------------------------------------
    localparam int RSOW_PC_W = 11;
    localparam logic [RSOW_PC_W-1:0] RSOW_START_ADDR = 11'h000;
    localparam int RSOW_TMR_W = 8;
    localparam int RSOW_WAIT_STAGES = 256;
    localparam int RSOW_WAIT_PER_STAGE = 256;
    localparam int RSOW_WAIT_CYCLES = RSOW_WAIT_STAGES * RSOW_WAIT_PER_STAGE;
    localparam int RSOW_CNT_W = 17;
    localparam logic [RSOW_CNT_W-1:0] RSOW_CNT_ONE = 17'h00001;
    localparam logic [RSOW_CNT_W-1:0] RSOW_CNT_ZERO = 17'h00000;
    localparam logic [RSOW_TMR_W-1:0] RSOW_TMR_ZERO = 8'h00;
    localparam logic [RSOW_TMR_W-1:0] RSOW_TMR_ONE = 8'h01;

    // -------------------------------------------------------------------------
    // Sequencer states
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RSOW_HOLD,
        RSOW_WAIT,
        RSOW_RUN
    } rsow_state_t;
endpackage

// ### src/rsow_sequencer.sv
// Reset sequencer: merges the external pin, power-on, power-drop and stack
// fault resets, stops the oscillator, runs the stability wait, starts at zero.
// Assumes all inputs are synchronous to clk_in and the detectors give levels.
//
// Contract
// - A rising edge on the external reset pin starts the clock and the stability wait.
// - After any reset the core starts fetching at program address zero.
// - The stability wait lasts 256 times 256 system clocks before operation begins.
// - A stack fault reset skips the wait and resumes at address zero at once.
// - A power-on reset drives the internal reset and follows the pin reset sequence.
// - Power-on reset initialises regardless of oscillation and is followed by the timed wait.
// - The power-drop reset acts only while its software enable flag is set.
// - A detected supply drop holds reset with the oscillator halted until recovery.
// - When the supply recovers from a drop the wait runs, then execution restarts at zero.
// - The oscillator is stopped while a power-drop reset is asserted.
// - Recovery from a full collapse to zero volts is handled by the power-on path first.
`timescale 1ns/1ns
`default_nettype none
module rsow_sequencer
    import rsow_pkg::*;
#(
    parameter int WAIT_STAGE_LEN = RSOW_WAIT_PER_STAGE,
    parameter int WAIT_STAGES = RSOW_WAIT_STAGES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reset_pin_n_in,
    input wire logic power_on_det_in,
    input wire logic power_drop_det_in,
    input wire logic power_drop_reset_enable_in,
    input wire logic stack_fault_in,
    output logic osc_enable_out,
    output logic core_reset_out,
    output logic fetch_start_out,
    output logic [RSOW_PC_W-1:0] start_addr_out,
    output logic waiting_out,
    output logic power_drop_active_out
);
    // -------------------------------------------------------------------------
    // Reset source merge
    // -------------------------------------------------------------------------
    // The drop detector only counts while software has enabled it.
    logic pin_rst;
    logic por_rst;
    logic drop_rst;
    logic hard_rst;
    assign pin_rst = !reset_pin_n_in;
    assign por_rst = power_on_det_in;
    assign drop_rst = power_drop_det_in && power_drop_reset_enable_in;
    // Power-on and a drop are ORed with equal weight; both lead to the same hold-then-wait path.
    assign hard_rst = pin_rst || por_rst || drop_rst;

    // -------------------------------------------------------------------------
    // Stability wait timer
    // -------------------------------------------------------------------------
    rsow_state_t state_q;
    rsow_state_t state_d;
    logic tmr_clear;
    logic tmr_run;
    logic tmr_done;

    rsow_wait_timer #(
        .STAGE_LEN(WAIT_STAGE_LEN),
        .STAGES(WAIT_STAGES)
    ) u_wait (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .clear_in(tmr_clear),
        .run_in(tmr_run),
        .done_out(tmr_done)
    );

    // The timer is cleared while any hard source holds and on the way into
    // the wait, so every release counts the full span from zero.
    always_comb begin
        tmr_clear = 1'b0;
        tmr_run = 1'b0;
        if (hard_rst) begin
            tmr_clear = 1'b1;
        end else if (!stack_fault_in) begin
            unique case (state_q)
                RSOW_HOLD: begin
                    tmr_clear = 1'b1;
                end
                RSOW_WAIT: begin
                    tmr_run = 1'b1;
                end
                RSOW_RUN: begin
                    tmr_run = 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Sequencer state
    // -------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (hard_rst) begin
            state_d = RSOW_HOLD;
        end else if (stack_fault_in) begin
            // The clock is already stable, so no wait is needed.
            state_d = RSOW_RUN;
        end else begin
            unique case (state_q)
                RSOW_HOLD: begin
                    state_d = RSOW_WAIT;
                end
                RSOW_WAIT: begin
                    if (tmr_done) begin
                        state_d = RSOW_RUN;
                    end
                end
                RSOW_RUN: begin
                    state_d = RSOW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= RSOW_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // -------------------------------------------------------------------------
    // Oscillator enable
    // -------------------------------------------------------------------------
    logic osc_q;
    logic osc_d;

    always_comb begin
        osc_d = osc_q;
        if (hard_rst) begin
            // Halting the oscillator keeps the program from running wild while
            // the supply is out of range.
            osc_d = 1'b0;
        end else if (stack_fault_in) begin
            osc_d = 1'b1;
        end else begin
            unique case (state_q)
                RSOW_HOLD: begin
                    osc_d = 1'b1;
                end
                RSOW_WAIT: begin
                    osc_d = osc_q;
                end
                RSOW_RUN: begin
                    osc_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= osc_d;
        end
    end

    // -------------------------------------------------------------------------
    // Core reset
    // -------------------------------------------------------------------------
    logic core_rst_q;
    logic core_rst_d;

    // A new hard source during the wait restarts it from zero; time already
    // counted earns no credit, which favours safety over a quick restart.
    always_comb begin
        core_rst_d = core_rst_q;
        if (hard_rst) begin
            core_rst_d = 1'b1;
        end else if (stack_fault_in) begin
            core_rst_d = 1'b0;
        end else begin
            unique case (state_q)
                RSOW_HOLD: begin
                    core_rst_d = core_rst_q;
                end
                RSOW_WAIT: begin
                    if (tmr_done) begin
                        core_rst_d = 1'b0;
                    end
                end
                RSOW_RUN: begin
                    core_rst_d = core_rst_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_rst_q <= 1'b1;
        end else begin
            core_rst_q <= core_rst_d;
        end
    end

    // -------------------------------------------------------------------------
    // Fetch strobe
    // -------------------------------------------------------------------------
    logic fetch_q;
    logic fetch_d;

    // A stack fault held for several cycles repeats the strobe each cycle.
    always_comb begin
        fetch_d = 1'b0;
        if (hard_rst) begin
            fetch_d = 1'b0;
        end else if (stack_fault_in) begin
            fetch_d = 1'b1;
        end else begin
            unique case (state_q)
                RSOW_HOLD: begin
                    fetch_d = 1'b0;
                end
                RSOW_WAIT: begin
                    fetch_d = tmr_done;
                end
                RSOW_RUN: begin
                    fetch_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= fetch_d;
        end
    end

    // -------------------------------------------------------------------------
    // Wait flag
    // -------------------------------------------------------------------------
    logic wait_q;
    logic wait_d;

    // Taken from the next state so that the flag rises with the oscillator.
    always_comb begin
        wait_d = (state_d == RSOW_WAIT);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
        end
    end

    // -------------------------------------------------------------------------
    // Power-drop flag
    // -------------------------------------------------------------------------
    logic drop_act_q;
    logic drop_act_d;

    always_comb begin
        drop_act_d = drop_rst;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            drop_act_q <= 1'b0;
        end else begin
            drop_act_q <= drop_act_d;
        end
    end

    // -------------------------------------------------------------------------
    // Start address
    // -------------------------------------------------------------------------
    logic [RSOW_PC_W-1:0] addr_q;
    logic [RSOW_PC_W-1:0] addr_d;

    always_comb begin
        addr_d = RSOW_START_ADDR;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            addr_q <= RSOW_START_ADDR;
        end else begin
            addr_q <= addr_d;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign osc_enable_out = osc_q;
    assign core_reset_out = core_rst_q;
    assign fetch_start_out = fetch_q;
    assign start_addr_out = addr_q;
    assign waiting_out = wait_q;
    assign power_drop_active_out = drop_act_q;
endmodule
`default_nettype wire

// ### src/rsow_wait_timer.sv
// Oscillation-stability wait timer: a 9-bit prescaler feeding a 9-bit count.
// Assumes the caller clears it while reset is held and enables it during the wait.
`timescale 1ns/1ns
`default_nettype none
module rsow_wait_timer
    import rsow_pkg::*;
#(
    parameter int STAGE_LEN = RSOW_WAIT_PER_STAGE,
    parameter int STAGES = RSOW_WAIT_STAGES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clear_in,
    input wire logic run_in,
    output logic done_out
);
    // -------------------------------------------------------------------------
    // Prescaler and stage count
    // -------------------------------------------------------------------------
    localparam logic [RSOW_TMR_W:0] STAGE_LAST = (RSOW_TMR_W+1)'(STAGE_LEN - 1);
    localparam logic [RSOW_TMR_W:0] STAGES_LAST = (RSOW_TMR_W+1)'(STAGES - 1);
    logic [RSOW_TMR_W:0] pre_q;
    logic [RSOW_TMR_W:0] pre_d;
    logic [RSOW_TMR_W:0] stg_q;
    logic [RSOW_TMR_W:0] stg_d;
    logic done_q;
    logic done_d;

    always_comb begin
        pre_d = pre_q;
        stg_d = stg_q;
        done_d = done_q;
        if (clear_in) begin
            pre_d = '0;
            stg_d = '0;
            done_d = 1'b0;
        end else if (run_in && !done_q) begin
            if (pre_q == STAGE_LAST) begin
                pre_d = '0;
                if (stg_q == STAGES_LAST) begin
                    done_d = 1'b1;
                end else begin
                    stg_d = stg_q + 1'b1;
                end
            end else begin
                pre_d = pre_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pre_q <= '0;
            stg_q <= '0;
            done_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            stg_q <= stg_d;
            done_q <= done_d;
        end
    end

    assign done_out = done_q;
endmodule
`default_nettype wire

// ### testbench/rsow_checker_asserts.sv
// Checker for the reset sequencer, watching only its ports.
// Assumes the bind below and one clock domain.
`timescale 1ns/1ns
`default_nettype none
module rsow_checker
    import rsow_pkg::*;
#(parameter int WAIT_STAGE_LEN = 4, parameter int WAIT_STAGES = 4) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reset_pin_n_in,
    input wire logic power_on_det_in,
    input wire logic power_drop_det_in,
    input wire logic power_drop_reset_enable_in,
    input wire logic stack_fault_in,
    input wire logic osc_enable_out,
    input wire logic core_reset_out,
    input wire logic fetch_start_out,
    input wire logic [RSOW_PC_W-1:0] start_addr_out,
    input wire logic waiting_out,
    input wire logic power_drop_active_out
);
    localparam int N = WAIT_STAGE_LEN * WAIT_STAGES;
    logic hard;
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    assign hard = !reset_pin_n_in || power_on_det_in || (power_drop_det_in && power_drop_reset_enable_in);
    always_comb begin
        cnt_d = waiting_out ? cnt_q + 17'h00001 : 17'h00000;
    end
    always_ff @(posedge clk_in) begin
        cnt_q <= srst_in ? 17'h00000 : cnt_d;
    end
    // -------------------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_hard_stops_osc: assert property (hard |=> !osc_enable_out && core_reset_out)
        else $error("hard reset did not halt");
    a_drop_needs_enable: assert property (power_drop_det_in && !power_drop_reset_enable_in
        |=> !power_drop_active_out)
        else $error("drop active while disabled");
    a_drop_osc_off: assert property (power_drop_active_out |-> !osc_enable_out && core_reset_out)
        else $error("osc runs during drop");
    a_release_wait: assert property ($fell(hard) |=> waiting_out && osc_enable_out)
        else $error("no wait after release");
    a_wait_holds_core: assert property (waiting_out |-> core_reset_out)
        else $error("core free during wait");
    a_wait_bounded: assert property (waiting_out |-> cnt_q < N + 4)
        else $error("wait too long");
    a_wait_full: assert property ($fell(waiting_out) && !core_reset_out && !$past(stack_fault_in)
        |-> cnt_q >= N - 1)
        else $error("wait too short");
    a_fetch_at_zero: assert property (fetch_start_out |-> start_addr_out == RSOW_START_ADDR
        ##1 !fetch_start_out)
        else $error("bad fetch");
    a_stack_no_wait: assert property ($rose(stack_fault_in) && !hard |=> fetch_start_out && !waiting_out)
        else $error("stack reset waited");
    c_fetch: cover property (waiting_out ##1 fetch_start_out);
    c_drop: cover property (power_drop_active_out);
    c_stack: cover property ($rose(stack_fault_in) && waiting_out);
endmodule
bind rsow_sequencer rsow_checker #(.WAIT_STAGE_LEN(WAIT_STAGE_LEN), .WAIT_STAGES(WAIT_STAGES)) u_chk (.*);
`default_nettype wire

// ### testbench/rsow_supply_model.sv
// Model of the reset pin and supply monitors.
// Assumes the bench requests events as levels.
`timescale 1ns/1ns
`default_nettype none
module rsow_supply_model (
    input wire logic clk_in,
    input wire logic pin_low_in,
    input wire logic power_up_in,
    input wire logic supply_low_in,
    output logic reset_pin_n_out = 1'b1,
    output logic power_on_det_out = 1'b0,
    output logic power_drop_det_out = 1'b0
);
    // Monitors lag the supply by one clock, as real detectors do.
    always_ff @(posedge clk_in) begin
        reset_pin_n_out <= !pin_low_in;
        power_on_det_out <= power_up_in;
        power_drop_det_out <= supply_low_in;
    end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Bench for the reset sequencer with the supply model.
// Assumes a 4 by 4 wait of 16 clocks.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rsow_pkg::*;
    localparam int N = 16;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic en = 1'b0;
    logic stack = 1'b0;
    logic pin_low = 1'b0;
    logic pwr_up = 1'b0;
    logic sup_low = 1'b0;
    logic pin_n, por, drop, osc, core, fetch, waiting, active;
    logic [RSOW_PC_W-1:0] addr;
    int mismatches = 0;
    int tests_run = 0;
    always #5 clk_in = !clk_in;
    rsow_supply_model u_sup (.clk_in(clk_in), .pin_low_in(pin_low), .power_up_in(pwr_up), .supply_low_in(sup_low),
        .reset_pin_n_out(pin_n), .power_on_det_out(por), .power_drop_det_out(drop));
    rsow_sequencer #(.WAIT_STAGE_LEN(4), .WAIT_STAGES(4)) DUT (.clk_in(clk_in), .srst_in(srst_in),
        .reset_pin_n_in(pin_n), .power_on_det_in(por), .power_drop_det_in(drop), .power_drop_reset_enable_in(en),
        .stack_fault_in(stack), .osc_enable_out(osc), .core_reset_out(core), .fetch_start_out(fetch),
        .start_addr_out(addr), .waiting_out(waiting), .power_drop_active_out(active));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic expect_fetch(input int lo, input int hi);
        int n;
        n = 0;
        while (fetch !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("fetch delay", 11'h001, 11'(n >= lo && n <= hi));
        check("start addr", RSOW_START_ADDR, addr);
        check("core free", 11'h000, 11'(core));
    endtask
    task automatic hard_cycle(input int src);
        @(posedge clk_in);
        en <= (src >= 2);
        pin_low <= (src == 0);
        pwr_up <= (src == 1 || src == 3);
        sup_low <= (src >= 2);
        repeat (5) @(posedge clk_in);
        #1;
        check("osc", 11'h000, 11'(osc));
        check("core held", 11'h001, 11'(core));
        check("drop flag", 11'(src >= 2), 11'(active));
        @(posedge clk_in);
        pin_low <= 1'b0;
        pwr_up <= 1'b0;
        sup_low <= 1'b0;
        #1;
        expect_fetch(N, N + 8);
    endtask
    task automatic drop_refused();
        @(posedge clk_in);
        en <= 1'b0;
        sup_low <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        check("drop ignored", 11'h000, 11'(core | active));
        @(posedge clk_in);
        en <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        check("drop honoured", 11'h001, 11'(core & active & !osc));
        @(posedge clk_in);
        sup_low <= 1'b0;
        #1;
        expect_fetch(N, N + 8);
    endtask
    task automatic stack_reset(input logic in_wait);
        @(posedge clk_in);
        pin_low <= in_wait;
        @(posedge clk_in);
        pin_low <= 1'b0;
        repeat (6) @(posedge clk_in);
        #1;
        check("waiting", 11'(in_wait), 11'(waiting));
        @(posedge clk_in);
        stack <= 1'b1;
        @(posedge clk_in);
        stack <= 1'b0;
        #1;
        expect_fetch(0, 3);
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        expect_fetch(N, N + 8);
        hard_cycle(0);
        hard_cycle(1);
        hard_cycle(2);
        hard_cycle(3);
        drop_refused();
        stack_reset(1'b0);
        stack_reset(1'b1);
        end_sim();
    end
    initial begin
        #50000;
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
